// ### sdc_pkg.sv
// Purpose: constants for the sdram command timing controller
// Assumes: 125 MHz controller clock, four banks, 32-bit data
// Notes: base times in ps except T_REF_MS in ms, counts derived from the ps times
`default_nettype none
package sdc_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_REFI_PS = 15600000;
  localparam int T_REF_MS = 64;
  localparam int T_RAS_PS = 42000;
  localparam int T_RP_PS = 18000;
  localparam int T_RCD_PS = 18000;
  localparam int T_RRD_PS = 12000;
  localparam int T_DPL_PS = 7000;
  localparam int T_RSC_PS = 12000;
  localparam int T_CKSP_PS = 1500;
  localparam int RD_END_TO_WR_GAP = 2;
  localparam int CLK_DISABLE_LATENCY = 1;

  // least time: round up, never below one cycle
  function automatic int cyc_min(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  // longest time: round down, never below one cycle
  function automatic int cyc_max(input int ps);
    int c;
    c = ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_max

  localparam int N_REFI = cyc_max(T_REFI_PS);
  localparam int N_RAS = cyc_min(T_RAS_PS);
  localparam int N_RP = cyc_min(T_RP_PS);
  localparam int N_RC = N_RAS + N_RP;
  localparam int N_RCD = cyc_min(T_RCD_PS);
  localparam int N_RRD = cyc_min(T_RRD_PS);
  localparam int N_DPL = cyc_min(T_DPL_PS);
  localparam int N_RSC = cyc_min(T_RSC_PS);
  localparam int N_CKSP = cyc_min(T_CKSP_PS);

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam int AP_BIT = 10;
  localparam int MODE_CL_POS = 4;

  typedef enum logic [2:0] {
    SDC_INIT = 3'h0,
    SDC_IDLE = 3'h1,
    SDC_RCD = 3'h3,
    SDC_COL = 3'h2,
    SDC_REFW = 3'h6,
    SDC_PD = 3'h7,
    SDC_SR = 3'h5,
    SDC_SRX = 3'h4
  } sdc_state_e;
endpackage : sdc_pkg
`default_nettype wire

// ### sdc_ctrl.sv
// Purpose: host controller driving a four-bank 32-bit sdram
// Assumes: closed-page accesses with auto-precharge, one at a time
// Notes: burst length and read latency are parameters
`default_nettype none
module sdc_ctrl #(
  parameter int RD_LAT = 3,
  parameter int BURST_LEN = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire logic req_we_i,
  input wire logic [1:0] req_bank_i,
  input wire logic [10:0] req_row_i,
  input wire logic [7:0] req_col_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic [3:0] req_be_i,
  input wire logic pd_req_i,
  input wire logic sr_req_i,
  input wire logic [31:0] dq_i,
  output logic req_ready_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic init_done_o,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [1:0] ba_o,
  output logic [10:0] addr_o,
  output logic [3:0] dqm_o,
  output logic [31:0] dq_o,
  output logic dq_oe_o
);
  localparam logic [7:0] W_RP = 8'(sdc_pkg::N_RP - 1);
  localparam logic [7:0] W_RC = 8'(sdc_pkg::N_RC - 1);
  localparam logic [7:0] W_RCD = 8'(sdc_pkg::N_RCD - 1);
  localparam logic [7:0] W_RSC = 8'(sdc_pkg::N_RSC - 1);
  localparam logic [7:0] W_CKSP = 8'(sdc_pkg::N_CKSP);
  localparam logic [7:0] W_SRX = 8'(sdc_pkg::N_CKSP + sdc_pkg::N_RC - 1);
  localparam logic [3:0] L_RRD = 4'(sdc_pkg::N_RRD - 1);
  localparam logic [3:0] L_RDGAP = 4'(RD_LAT + BURST_LEN + sdc_pkg::RD_END_TO_WR_GAP - 2);
  localparam logic [4:0] B_RC = 5'(sdc_pkg::N_RC - 1);
  localparam logic [4:0] B_WRA = 5'(BURST_LEN + ((RD_LAT == 3) ? 1 : 0) + sdc_pkg::N_RP
                                    + sdc_pkg::N_DPL - 2);
  localparam logic [4:0] B_RDA = 5'(BURST_LEN + sdc_pkg::N_RP - 1);
  localparam logic [10:0] MODE_WORD = 11'(RD_LAT << sdc_pkg::MODE_CL_POS);
  localparam logic [11:0] L_REFI = 12'(sdc_pkg::N_REFI - 1);

  function automatic logic [4:0] bmax(input logic [4:0] a, input logic [4:0] b);
    return (a > b) ? a : b;
  endfunction : bmax

  sdc_pkg::sdc_state_e state_r;
  logic [7:0] wait_r;
  logic [1:0] init_step_r;
  logic [3:0] bank_to_bank_activate_delay_r;
  logic [3:0] rd_gap_r;
  logic [4:0] bank_cnt_r [4];
  logic [11:0] refi_r;
  logic ref_pend_r;
  logic [RD_LAT:0] rd_pipe_r;
  logic [3:0] cmd_r;
  logic we_r;
  logic [1:0] bank_r;
  logic [7:0] col_r;
  logic [31:0] wdata_r;
  logic [3:0] be_r;
  logic banks_idle;
  logic [3:0] cmd_nxt;
  logic issue_ref;

  assign banks_idle = (bank_cnt_r[0] == 5'h00) && (bank_cnt_r[1] == 5'h00) &&
                      (bank_cnt_r[2] == 5'h00) && (bank_cnt_r[3] == 5'h00);
  assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd_r;
  assign issue_ref = (cmd_nxt == sdc_pkg::CMD_REF);

  // next command, one source for the sequencer and every counter
  always_comb begin
    cmd_nxt = sdc_pkg::CMD_NOP;
    case (state_r)
      sdc_pkg::SDC_INIT: begin
        if (wait_r == 8'h00) begin
          case (init_step_r)
            2'h0: cmd_nxt = sdc_pkg::CMD_PRE;
            2'h1, 2'h2: cmd_nxt = sdc_pkg::CMD_REF;
            default: cmd_nxt = sdc_pkg::CMD_MRS;
          endcase
        end
      end
      sdc_pkg::SDC_IDLE: begin
        if ((wait_r == 8'h00) && (ref_pend_r || sr_req_i) && banks_idle) begin
          cmd_nxt = sdc_pkg::CMD_REF;
        end else if ((wait_r == 8'h00) && !ref_pend_r && !sr_req_i && !pd_req_i &&
                     req_valid_i && (bank_cnt_r[req_bank_i] == 5'h00) && (bank_to_bank_activate_delay_r == 4'h0)) begin
          cmd_nxt = sdc_pkg::CMD_ACT;
        end
      end
      sdc_pkg::SDC_COL: begin
        if ((wait_r == 8'h00) && (!we_r || (rd_gap_r == 4'h0))) begin
          cmd_nxt = we_r ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD;
        end
      end
      default: cmd_nxt = sdc_pkg::CMD_NOP;
    endcase
  end

  // command sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= sdc_pkg::SDC_INIT;
      wait_r <= 8'h00;
      init_step_r <= 2'h0;
      cmd_r <= sdc_pkg::CMD_NOP;
      cke_o <= 1'b1;
      ba_o <= 2'h0;
      addr_o <= 11'h000;
      dqm_o <= 4'hf;
      dq_o <= 32'h0;
      dq_oe_o <= 1'b0;
      req_ready_o <= 1'b0;
      init_done_o <= 1'b0;
      we_r <= 1'b0;
      bank_r <= 2'h0;
      col_r <= 8'h00;
      wdata_r <= 32'h0;
      be_r <= 4'h0;
    end else begin
      req_ready_o <= 1'b0;
      dq_oe_o <= 1'b0;
      dqm_o <= (cmd_r == sdc_pkg::CMD_RD) ? 4'h0 : 4'hf;
      if (wait_r != 8'h00) wait_r <= wait_r - 8'h01;
      case (state_r)
        sdc_pkg::SDC_INIT: begin
          if (wait_r == 8'h00) begin
            init_step_r <= init_step_r + 2'h1;
            case (init_step_r)
              2'h0: begin
                addr_o <= 11'h400;
                wait_r <= W_RP;
              end
              2'h1, 2'h2: begin
                wait_r <= W_RC;
              end
              default: begin
                addr_o <= MODE_WORD;
                ba_o <= 2'h0;
                wait_r <= W_RSC;
                init_done_o <= 1'b1;
                state_r <= sdc_pkg::SDC_IDLE;
              end
            endcase
          end
        end
        sdc_pkg::SDC_IDLE: begin
          if (wait_r == 8'h00) begin
            if (ref_pend_r) begin
              if (banks_idle) begin
                wait_r <= W_RC;
                state_r <= sdc_pkg::SDC_REFW;
              end
            end else if (sr_req_i) begin
              if (banks_idle) begin
                cke_o <= 1'b0;
                state_r <= sdc_pkg::SDC_SR;
              end
            end else if (pd_req_i) begin
              // no sleep while a bank still precharges or read data is due
              if (banks_idle) begin
                cke_o <= 1'b0;
                state_r <= sdc_pkg::SDC_PD;
              end
            end else if (req_valid_i && (bank_cnt_r[req_bank_i] == 5'h00) &&
                         (bank_to_bank_activate_delay_r == 4'h0)) begin
              ba_o <= req_bank_i;
              addr_o <= req_row_i;
              req_ready_o <= 1'b1;
              we_r <= req_we_i;
              bank_r <= req_bank_i;
              col_r <= req_col_i;
              wdata_r <= req_wdata_i;
              be_r <= req_be_i;
              wait_r <= W_RCD;
              state_r <= sdc_pkg::SDC_COL;
            end
          end
        end
        sdc_pkg::SDC_COL: begin
          if ((wait_r == 8'h00) && (!we_r || (rd_gap_r == 4'h0))) begin
            ba_o <= bank_r;
            addr_o <= {1'b1, 2'h0, col_r};
            if (we_r) begin
              dq_o <= wdata_r;
              dq_oe_o <= 1'b1;
              dqm_o <= ~be_r;
            end
            state_r <= sdc_pkg::SDC_IDLE;
          end
        end
        sdc_pkg::SDC_REFW: begin
          if (wait_r == 8'h00) state_r <= sdc_pkg::SDC_IDLE;
        end
        sdc_pkg::SDC_PD: begin
          if (!pd_req_i || ref_pend_r) begin
            cke_o <= 1'b1;
            wait_r <= W_CKSP;
            state_r <= sdc_pkg::SDC_IDLE;
          end
        end
        sdc_pkg::SDC_SR: begin
          if (!sr_req_i) begin
            cke_o <= 1'b1;
            wait_r <= W_SRX;
            state_r <= sdc_pkg::SDC_SRX;
          end
        end
        sdc_pkg::SDC_SRX: begin
          if (wait_r == 8'h00) state_r <= sdc_pkg::SDC_IDLE;
        end
        default: state_r <= sdc_pkg::SDC_INIT;
      endcase
      cmd_r <= cmd_nxt;
    end
  end

  // per-bank busy counters and cross-bank spacing
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) bank_cnt_r[i] <= 5'h00;
      bank_to_bank_activate_delay_r <= 4'h0;
      rd_gap_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (bank_cnt_r[i] != 5'h00) bank_cnt_r[i] <= bank_cnt_r[i] - 5'h01;
      end
      if (bank_to_bank_activate_delay_r != 4'h0) bank_to_bank_activate_delay_r <= bank_to_bank_activate_delay_r - 4'h1;
      if (rd_gap_r != 4'h0) rd_gap_r <= rd_gap_r - 4'h1;
      if (cmd_nxt == sdc_pkg::CMD_ACT) begin
        bank_cnt_r[req_bank_i] <= B_RC;
        bank_to_bank_activate_delay_r <= L_RRD;
      end
      if (cmd_nxt == sdc_pkg::CMD_WR) begin
        bank_cnt_r[bank_r] <= bmax(bank_cnt_r[bank_r] - 5'h01, B_WRA);
      end
      if (cmd_nxt == sdc_pkg::CMD_RD) begin
        bank_cnt_r[bank_r] <= bmax(bank_cnt_r[bank_r] - 5'h01, B_RDA);
        rd_gap_r <= L_RDGAP;
      end
    end
  end

  // refresh interval timer; reload on refresh wins over expiry
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      refi_r <= L_REFI;
      ref_pend_r <= 1'b0;
    end else if (issue_ref) begin
      refi_r <= L_REFI;
      ref_pend_r <= 1'b0;
    end else if (refi_r == 12'h000) begin
      refi_r <= L_REFI;
      ref_pend_r <= init_done_o;
    end else begin
      refi_r <= refi_r - 12'h001;
    end
  end

  // read return pipeline
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_pipe_r <= '0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 32'h0;
    end else begin
      rd_pipe_r <= {rd_pipe_r[RD_LAT-1:0], cmd_nxt == sdc_pkg::CMD_RD};
      rd_valid_o <= rd_pipe_r[RD_LAT];
      if (rd_pipe_r[RD_LAT]) rd_data_o <= dq_i;
    end
  end

  logic [12:0] ref_age_r;
  logic [1:0] wr_bank_r;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) ref_age_r <= 13'h0000;
    else if ((cmd_r == sdc_pkg::CMD_REF) || !cke_o || !init_done_o) ref_age_r <= 13'h0000;
    else ref_age_r <= ref_age_r + 13'h0001;
    if (cmd_r == sdc_pkg::CMD_WR) wr_bank_r <= ba_o;
  end

  property p_refi;
    @(posedge ref_clk_i) disable iff (!rst_n_i) ref_age_r < 13'h7c6;
  endproperty
  a_refi: assert property (p_refi) else $error("refresh overdue");
  property p_wr_data;
    @(posedge ref_clk_i) disable iff (!rst_n_i) (cmd_r == sdc_pkg::CMD_WR) |-> dq_oe_o;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data missing");
  property p_rd_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cmd_r == sdc_pkg::CMD_RD) |=> (cmd_r != sdc_pkg::CMD_WR) [*4];
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("write too soon after read");
  property p_rrd;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cmd_r == sdc_pkg::CMD_ACT) |=> (cmd_r != sdc_pkg::CMD_ACT);
  endproperty
  a_rrd: assert property (p_rrd) else $error("activates too close");
  property p_mrs;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cmd_r == sdc_pkg::CMD_MRS) |=> (cmd_r == sdc_pkg::CMD_NOP);
  endproperty
  a_mrs: assert property (p_mrs) else $error("command inside mode cycle");
  property p_pd_exit;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(cke_o) |-> (cmd_r != sdc_pkg::CMD_ACT) [*2];
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("activate too soon on wake");
  property p_srx_nop;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state_r == sdc_pkg::SDC_SRX) |-> (cmd_r == sdc_pkg::CMD_NOP) && cke_o;
  endproperty
  a_srx_nop: assert property (p_srx_nop) else $error("command during exit");
  property p_srx_cke;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ($rose(cke_o) && $past(state_r == sdc_pkg::SDC_SR)) |-> cke_o [*8];
  endproperty
  a_srx_cke: assert property (p_srx_cke) else $error("clock enable dropped");
  property p_wra;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cmd_r == sdc_pkg::CMD_WR) |=>
        !((cmd_r == sdc_pkg::CMD_ACT) && (ba_o == wr_bank_r)) [*4];
  endproperty
  a_wra: assert property (p_wra) else $error("bank reopened too soon");
  property p_act_col;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cmd_r == sdc_pkg::CMD_ACT) |=> (cmd_r == sdc_pkg::CMD_NOP) [*2];
  endproperty
  a_act_col: assert property (p_act_col) else $error("column before row ready");

  c_read: cover property (@(posedge ref_clk_i) rd_valid_o);
  c_write: cover property (@(posedge ref_clk_i) cmd_r == sdc_pkg::CMD_WR);
  c_ref: cover property (@(posedge ref_clk_i) state_r == sdc_pkg::SDC_REFW);
  c_srx: cover property (@(posedge ref_clk_i) state_r == sdc_pkg::SDC_SRX);
endmodule : sdc_ctrl
`default_nettype wire

// ### sdc_sdram_model.sv
// Purpose: behavioural four-bank sdram answering the controller pins
// Assumes: one word per access, read data launched one edge before it is due
// Notes: a released or masked byte shows the inverse of its last value
`default_nettype none
module sdc_sdram_model #(
  parameter int RD_LAT = 3
) (
  input wire logic clk_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [1:0] ba_i,
  input wire logic [10:0] addr_i,
  input wire logic [3:0] dqm_i,
  input wire logic [31:0] dq_i,
  output logic [31:0] dq_o,
  output logic drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [int];
  logic [10:0] row_r [4];
  logic [31:0] pend_w [$];
  int pend_t [$];
  logic cke_r = 1'b1;
  logic sr_r = 1'b0;
  logic [3:0] dqm_r = 4'hf;
  logic [31:0] w;
  int cyc = 0;
  int key;
  initial begin
    dq_o = 32'h0;
    drive_o = 1'b0;
  end
  always @(posedge clk_i) begin
    cyc++;
    key = 32'({ba_i, row_r[ba_i], addr_i[7:0]});
    if (drive_o) begin
      dq_o <= #1 ~dq_o;
      drive_o <= #1 1'b0;
    end
    if (pend_t.size() > 0 && pend_t[0] == cyc) begin
      w = pend_w.pop_front();
      void'(pend_t.pop_front());
      for (int i = 0; i < 4; i++) if (dqm_r[i]) w[8*i+:8] = ~dq_o[8*i+:8];
      dq_o <= #1 w;
      drive_o <= #1 (dqm_r != 4'hf);
    end
    if (sr_r && cke_i) begin
      sr_r = 1'b0;
    end else if (cke_r && !sr_r) begin
      case ({cs_n_i, ras_n_i, cas_n_i, we_n_i})
        sdc_pkg::CMD_ACT: row_r[ba_i] = addr_i;
        sdc_pkg::CMD_WR: begin
          w = mem.exists(key) ? mem[key] : 32'h0;
          for (int i = 0; i < 4; i++) if (!dqm_i[i]) w[8*i+:8] = dq_i[8*i+:8];
          mem[key] = w;
        end
        sdc_pkg::CMD_RD: begin
          pend_w.push_back(mem.exists(key) ? mem[key] : 32'h0);
          pend_t.push_back(cyc + RD_LAT - 1);
        end
        sdc_pkg::CMD_REF: if (!cke_i) sr_r = 1'b1;
        4'h6: begin // burst stop: words due at or past the stop latency never drive
          while (pend_t.size() > 0 && pend_t[$] >= cyc + RD_LAT - 1) begin
            void'(pend_t.pop_back());
            void'(pend_w.pop_back());
          end
        end
        default: ;
      endcase
    end
    dqm_r = dqm_i;
    cke_r = cke_i;
  end
endmodule : sdc_sdram_model
`default_nettype wire

// ### sdc_ctrl_tb_top.sv
// Purpose: self-checking bench for the sdram controller
// Assumes: read latency 3, one word per access
// Notes: pins watched every edge, reads checked against a reference memory
`default_nettype none
module sdc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CL = 3;
  logic clk, rst_n = 0, vld = 0, we = 0, pd = 0, sr = 0, ckp = 1, in_sr = 0;
  logic [1:0] bank = 0, ba;
  logic [10:0] row = 0, ad;
  logic [7:0] col = 0;
  logic [31:0] wd = 0, dqi, rdd, dqo;
  logic [3:0] be = 0, dqm;
  logic rdy, rdv, idone, cke, csn, rasn, casn, wen, oe, mdrv;
  int n_mismatch = 0, checks = 0, cyc = 0, t_act = -99, t_rde = -99, t_ref = 0, t_mrs = -99;
  int t_up = -99, t_srx = -99, t_ab[4] = '{default: -99}, t_wa[4] = '{default: -99};
  logic [31:0] refm [int];
  logic [31:0] expq [$];
  wire logic [3:0] cmd = {csn, rasn, casn, wen};
  sdc_ctrl #(.RD_LAT(CL), .BURST_LEN(1)) dut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .req_valid_i(vld), .req_we_i(we), .req_bank_i(bank), .req_row_i(row), .req_col_i(col),
    .req_wdata_i(wd), .req_be_i(be), .pd_req_i(pd), .sr_req_i(sr), .dq_i(dqi),
    .req_ready_o(rdy), .rd_valid_o(rdv), .rd_data_o(rdd), .init_done_o(idone), .cke_o(cke),
    .cs_n_o(csn), .ras_n_o(rasn), .cas_n_o(casn), .we_n_o(wen), .ba_o(ba), .addr_o(ad),
    .dqm_o(dqm), .dq_o(dqo), .dq_oe_o(oe));
  sdc_sdram_model #(.RD_LAT(CL)) mem_model (.clk_i(clk), .cke_i(cke), .cs_n_i(csn),
    .ras_n_i(rasn), .cas_n_i(casn), .we_n_i(wen), .ba_i(ba), .addr_i(ad), .dqm_i(dqm),
    .dq_i(dqo), .dq_o(dqi), .drive_o(mdrv));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic req(input logic w, input logic [1:0] b, input logic [10:0] r,
                     input logic [7:0] c);
    int k;
    k = 32'({b, r, c});
    @(negedge clk);
    vld = 1;
    we = w;
    bank = b;
    row = r;
    col = c;
    wd = $urandom;
    be = 4'($urandom);
    if (!refm.exists(k)) refm[k] = 32'h0;
    if (w) begin
      for (int i = 0; i < 4; i++) if (be[i]) refm[k][8*i+:8] = wd[8*i+:8];
    end else begin
      expq.push_back(refm[k]);
    end
    for (int n = 0; n < 5000 && rdy !== 1'b1; n++) @(negedge clk);
    chk("req_taken", rdy, 1);
    vld = 0;
  endtask : req
  // pin side timing watch, sampled as the device sees it
  always @(posedge clk) begin
    cyc++;
    if (!rst_n) begin
      t_ref = cyc;
      in_sr = 0;
    end else begin
      if (cke && !ckp) t_up = cyc;
      if (cke && !ckp && in_sr) begin
        t_srx = cyc;
        t_ref = cyc;
        in_sr = 0;
      end
      if (cyc - t_srx < sdc_pkg::N_CKSP + sdc_pkg::N_RC) begin
        chk("srx_cmd", 32'(cmd), 32'(sdc_pkg::CMD_NOP));
        chk("srx_cke", 32'(cke), 1);
      end
      chk("refi", 32'(in_sr || cyc - t_ref <= sdc_pkg::N_REFI + 20), 1);
      chk("contention", 32'(oe & mdrv), 0);
      if (cmd != sdc_pkg::CMD_NOP) chk("mrs_gap", 32'(cyc - t_mrs >= sdc_pkg::N_RSC), 1);
      case (cmd)
        sdc_pkg::CMD_ACT: begin
          chk("act_rrd", 32'(cyc - t_act >= sdc_pkg::N_RRD), 1);
          chk("act_rc", 32'(cyc - t_ab[ba] >= sdc_pkg::N_RC), 1);
          chk("act_wap", 32'(cyc - t_wa[ba] >= CL - 1 + sdc_pkg::N_RP), 1);
          chk("act_pd", 32'(cyc - t_up >= sdc_pkg::N_CKSP + 1), 1);
          t_act = cyc;
          t_ab[ba] = cyc;
        end
        sdc_pkg::CMD_RD: t_rde = cyc + CL;
        sdc_pkg::CMD_WR: begin
          chk("wr_gap", 32'(cyc - t_rde >= sdc_pkg::RD_END_TO_WR_GAP), 1);
          chk("wr_oe", 32'(oe), 1);
          if (ad[sdc_pkg::AP_BIT]) t_wa[ba] = cyc;
        end
        sdc_pkg::CMD_REF: begin
          if (!cke) in_sr = 1;
          t_ref = cyc;
        end
        sdc_pkg::CMD_MRS: t_mrs = cyc;
        default: ;
      endcase
    end
    ckp = cke;
  end
  always @(negedge clk) begin
    if (rdv === 1'b1) chk("rd_data", rdd, expq.size() > 0 ? expq.pop_front() : 32'hx);
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    void'($urandom(33928));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    for (int n = 0; n < 3000 && idone !== 1'b1; n++) @(negedge clk);
    chk("init_done", 32'(idone), 1);
    for (int n = 0; n < 60; n++) begin
      req(1'($urandom), 2'($urandom), 11'($urandom % 3), 8'($urandom % 6));
      repeat ($urandom % 3) @(negedge clk);
    end
    pd = 1;
    repeat (2500) @(negedge clk);
    pd = 0;
    req(0, 2'h1, 11'h1, 8'h1);
    sr = 1;
    repeat (300) @(negedge clk);
    sr = 0;
    for (int n = 0; n < 4; n++) req(0, 2'(n), 11'(n % 3), 8'(n));
    repeat (20) @(negedge clk);
    chk("rd_drained", 32'(expq.size()), 0);
    stop_test();
  end
endmodule : sdc_ctrl_tb_top
`default_nettype wire
